// ==== fagb_pkg.sv ====
/*
 * Shared constants and helper functions for the flash converter back end.
 * Assumes a single system clock domain; the converter clock is sampled as data.
 */
package fagb_pkg;

    localparam int unsigned COMP_COUNT  = 256;
    localparam int unsigned COLUMNS     = 4;
    localparam int unsigned COL_WIDTH   = 64;
    localparam int unsigned POS_W       = 6;
    localparam int unsigned CNT_W       = 7;
    localparam int unsigned WORD_W      = 8;
    localparam int unsigned SEL_W       = 3;

    localparam logic [WORD_W-1:0] WORD_RST    = 8'h00;
    localparam logic [WORD_W-1:0] WORD_TOP    = 8'hff;
    localparam logic [CNT_W-1:0]  CNT_RST     = 7'h00;
    localparam logic [SEL_W-1:0]  SEL_OVR     = 3'h4;

    // Number of set comparators in one column
    function automatic logic [CNT_W-1:0] fagb_count(input logic [COL_WIDTH-1:0] v);
        logic [CNT_W-1:0] n;
        n = CNT_RST;
        for (int i = 0; i < COL_WIDTH; i++) begin
            n = n + {6'h00, v[i]};
        end
        return n;
    endfunction

    function automatic logic [WORD_W-1:0] fagb_to_gray(input logic [WORD_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [WORD_W-1:0] fagb_from_gray(input logic [WORD_W-1:0] g);
        logic [WORD_W-1:0] b;
        b = WORD_RST;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            b[i] = (i == WORD_W - 1) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction

endpackage

// ==== fagb_column_decoder.sv ====
/*
 * One column decoder: reduces a 64-comparator slice to its position count
 * and holds it in a latch register between loads.
 * Assumes i_load is a one-cycle pulse from the same clock domain.
 */
module fagb_column_decoder
    import fagb_pkg::*;
#(
    parameter int unsigned SLICE_W = COL_WIDTH
) (
    // Clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_resetn,
    // Slice and load strobe
    input  wire logic                i_load,
    input  wire logic [SLICE_W-1:0]  i_slice,
    // Position count, 0 to 64
    output logic      [CNT_W-1:0]    o_position
);

    logic [CNT_W-1:0] position_r;
    logic [CNT_W-1:0] position_nxt;

    assign position_nxt = i_load ? fagb_count(i_slice) : position_r;
    assign o_position   = position_r;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            position_r <= CNT_RST;
        end else begin
            position_r <= position_nxt;
        end
    end

    a_column_holds: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        !i_load |=> $stable(position_r))
        else $error("column position changed without a load");

endmodule

// ==== fagb_backend.sv ====
/*
 * Digital back end of an 8-bit flash converter: comparator latch, four
 * column decoders, column merge, Gray coding and two alternating output banks.
 * Assumes the converter clock and comparator outputs are asynchronous to
 * i_mclk and much slower (several system cycles per phase).
 */
// Notes on behaviour
// - Comparators track while the converter clock is low and hold their decision at each rising edge.
// - The held decisions form a thermometer code whose count of set bits is the input level.
// - On each falling edge the code is loaded into four column decoders, each reducing 64 bits to a position.
// - Each column result sits in a 7-bit latch that is reloaded only on the falling edge.
// - The in-column position gives the 6 low bits and the selected column of four gives the 2 high bits.
// - Each bank drives its word through 8 output latches that change only when that bank is loaded.
// - A sample taken at one rising edge appears on the outputs at the next rising edge.
// - Every output word is Gray coded so adjacent levels differ in one bit.
// - The bottom level gives an all-zero word and the top gives overrange with the top code.
// - Each bank carries a ninth overrange bit for its own sample.
// - Each bank has a data-ready strobe and its complement.
module fagb_backend
    import fagb_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_resetn,
    // Converter clock and comparator outputs
    input  wire logic                   i_conv_clk,
    input  wire logic [COMP_COUNT-1:0]  i_comparator,
    // Bank A
    output logic      [WORD_W-1:0]      o_sample_word_bank_a,
    output logic                        o_overrange_bank_a,
    output logic                        o_ready_strobe_bank_a,
    output logic                        o_ready_strobe_n_bank_a,
    // Bank B
    output logic      [WORD_W-1:0]      o_sample_word_bank_b,
    output logic                        o_overrange_bank_b,
    output logic                        o_ready_strobe_bank_b,
    output logic                        o_ready_strobe_n_bank_b
);

    logic                   clk_s1_r;
    logic                   clk_s2_r;
    logic                   clk_prev_r;
    logic [COMP_COUNT-1:0]  comp_s1_r;
    logic [COMP_COUNT-1:0]  comp_s2_r;
    logic [COMP_COUNT-1:0]  therm_r;
    logic                   have_r;
    logic                   bank_sel_r;
    logic [WORD_W-1:0]      word_a_r;
    logic [WORD_W-1:0]      word_b_r;
    logic                   ovr_a_r;
    logic                   ovr_b_r;
    logic                   rdy_a_r;
    logic                   rdy_b_r;
    logic                   rdy_n_a_r;
    logic                   rdy_n_b_r;

    logic                   rise_w;
    logic                   fall_w;
    logic [CNT_W-1:0]       col_cnt_w [COLUMNS];
    logic [SEL_W-1:0]       full_cols_w;
    logic                   ovr_w;
    logic [POS_W-1:0]       pos_w;
    logic [WORD_W-1:0]      bin_w;
    logic [WORD_W-1:0]      gray_w;
    logic                   load_a_w;
    logic                   load_b_w;

    // Two-stage synchronisers; only the second stage is looked at
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            clk_s1_r   <= 1'b0;
            clk_s2_r   <= 1'b0;
            clk_prev_r <= 1'b0;
            comp_s1_r  <= '0;
            comp_s2_r  <= '0;
        end else begin
            clk_s1_r   <= i_conv_clk;
            clk_s2_r   <= clk_s1_r;
            clk_prev_r <= clk_s2_r;
            comp_s1_r  <= i_comparator;
            comp_s2_r  <= comp_s1_r;
        end
    end

    assign rise_w = clk_s2_r & ~clk_prev_r;
    assign fall_w = ~clk_s2_r & clk_prev_r;

    // Comparator master stage tracks while low; slave holds from the rise
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            therm_r <= '0;
        end else if (rise_w) begin
            therm_r <= comp_s2_r;
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < COLUMNS; gc++) begin : g_col
            fagb_column_decoder #(
                .SLICE_W (COL_WIDTH)
            ) u_col (
                .i_mclk     (i_mclk),
                .i_resetn   (i_resetn),
                .i_load     (fall_w),
                .i_slice    (therm_r[gc*COL_WIDTH +: COL_WIDTH]),
                .o_position (col_cnt_w[gc])
            );
        end
    endgenerate

    // Full columns pick the two high bits; the partial column gives the rest
    assign full_cols_w = {2'b00, col_cnt_w[0][POS_W]} + {2'b00, col_cnt_w[1][POS_W]}
                       + {2'b00, col_cnt_w[2][POS_W]} + {2'b00, col_cnt_w[3][POS_W]};
    assign ovr_w       = (full_cols_w == SEL_OVR);
    assign pos_w       = ovr_w ? POS_W'(0) : col_cnt_w[full_cols_w[1:0]][POS_W-1:0];
    assign bin_w       = ovr_w ? WORD_TOP : {full_cols_w[1:0], pos_w};
    assign gray_w      = fagb_to_gray(bin_w);

    assign load_a_w    = rise_w & have_r & ~bank_sel_r;
    assign load_b_w    = rise_w & have_r & bank_sel_r;

    // First rise after reset has no decoded sample yet
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            have_r     <= 1'b0;
            bank_sel_r <= 1'b0;
        end else begin
            have_r     <= have_r | fall_w;
            bank_sel_r <= bank_sel_r ^ (load_a_w | load_b_w);
        end
    end

    // Output latches, loaded one converter cycle after the sample was taken
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            word_a_r  <= WORD_RST;
            ovr_a_r   <= 1'b0;
            rdy_a_r   <= 1'b0;
            rdy_n_a_r <= 1'b1;
        end else if (load_a_w) begin
            word_a_r  <= gray_w;
            ovr_a_r   <= ovr_w;
            rdy_a_r   <= ~rdy_a_r;
            rdy_n_a_r <= rdy_a_r;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            word_b_r  <= WORD_RST;
            ovr_b_r   <= 1'b0;
            rdy_b_r   <= 1'b0;
            rdy_n_b_r <= 1'b1;
        end else if (load_b_w) begin
            word_b_r  <= gray_w;
            ovr_b_r   <= ovr_w;
            rdy_b_r   <= ~rdy_b_r;
            rdy_n_b_r <= rdy_b_r;
        end
    end

    assign o_sample_word_bank_a    = word_a_r;
    assign o_overrange_bank_a      = ovr_a_r;
    assign o_ready_strobe_bank_a   = rdy_a_r;
    assign o_ready_strobe_n_bank_a = rdy_n_a_r;
    assign o_sample_word_bank_b    = word_b_r;
    assign o_overrange_bank_b      = ovr_b_r;
    assign o_ready_strobe_bank_b   = rdy_b_r;
    assign o_ready_strobe_n_bank_b = rdy_n_b_r;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    a_latch_on_rise: assert property (rise_w |=> therm_r == $past(comp_s2_r))
        else $error("comparators not latched at rising edge");

    a_latch_holds: assert property (!rise_w |=> $stable(therm_r))
        else $error("latched comparators changed away from a rising edge");

    a_column_load: assert property (fall_w |=> col_cnt_w[3] == fagb_count(therm_r[255:192]))
        else $error("top column position wrong after falling edge");

    a_gray_word_a: assert property (load_a_w |=> fagb_from_gray(o_sample_word_bank_a) == $past(bin_w))
        else $error("bank A word is not the Gray code of the sample");

    a_gray_word_b: assert property (load_b_w |=> fagb_from_gray(o_sample_word_bank_b) == $past(bin_w))
        else $error("bank B word is not the Gray code of the sample");

    a_overrange_top: assert property (load_b_w && &col_cnt_w[0][POS_W] && &col_cnt_w[1][POS_W]
        && col_cnt_w[2] == 7'h40 && col_cnt_w[3] == 7'h40
        |=> o_overrange_bank_b && o_sample_word_bank_b == 8'h80)
        else $error("top level does not give overrange and top code");

    a_ready_toggle: assert property (load_a_w |=> o_ready_strobe_bank_a != $past(o_ready_strobe_bank_a)
        && $stable(o_ready_strobe_bank_b))
        else $error("bank A ready did not toggle alone");

    a_ready_toggle_b: assert property (load_b_w |=> o_ready_strobe_bank_b != $past(o_ready_strobe_bank_b)
        && $stable(o_ready_strobe_bank_a))
        else $error("bank B ready did not toggle alone");

    a_ready_compl: assert property (o_ready_strobe_n_bank_b == !o_ready_strobe_bank_b
        && o_ready_strobe_n_bank_a == !o_ready_strobe_bank_a)
        else $error("ready strobe and complement disagree");

    a_bank_alternate: assert property (load_a_w |=> bank_sel_r && !load_a_w)
        else $error("bank A loaded twice in a row");

    a_bank_hold: assert property (!load_a_w |=> $stable(o_sample_word_bank_a) && $stable(o_overrange_bank_a))
        else $error("bank A output changed without a load");

    a_latency_one: assert property (rise_w && have_r |=>
        o_ready_strobe_bank_a != $past(o_ready_strobe_bank_a)
        || o_ready_strobe_bank_b != $past(o_ready_strobe_bank_b))
        else $error("decoded sample not presented at the next rising edge");

    c_load_a: cover property (load_a_w);
    c_load_b: cover property (load_b_w);
    c_overrange: cover property (load_a_w && ovr_w);
    c_zero_word: cover property (load_b_w && bin_w == WORD_RST);
    c_alternate: cover property (load_a_w ##[1:20] load_b_w);

endmodule

// ==== fagb_capture_model.sv ====
/*
 * Receiving capture logic for the two output banks of the converter back end.
 * Assumes the bank outputs are registers in the i_mclk domain.
 */
module fagb_capture_model
    import fagb_pkg::*;
(
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    // Bank A
    input  wire logic [WORD_W-1:0] i_word_a,
    input  wire logic              i_rdy_a,
    // Bank B
    input  wire logic [WORD_W-1:0] i_word_b,
    input  wire logic              i_rdy_b,
    // Capture record
    output logic      [7:0]        o_count,
    output logic      [WORD_W-1:0] o_word,
    output logic                   o_bank
);
    timeunit 1ns;
    timeprecision 1ps;

    logic prev_a_r;
    logic prev_b_r;

    // Each bank is taken on its own ready edge
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
            o_count  <= 8'h00;
            o_word   <= 8'h00;
            o_bank   <= 1'b0;
        end else begin
            prev_a_r <= i_rdy_a;
            prev_b_r <= i_rdy_b;
            if (i_rdy_a != prev_a_r) begin
                o_word  <= i_word_a;
                o_bank  <= 1'b0;
                o_count <= o_count + 8'h01;
            end else if (i_rdy_b != prev_b_r) begin
                o_word  <= i_word_b;
                o_bank  <= 1'b1;
                o_count <= o_count + 8'h01;
            end
        end
    end
endmodule

// ==== fagb_backend_tb.sv ====
/*
 * Testbench of the converter back end: a table of input levels, bubbled
 * codes and a reset in mid-run. Assumes the converter clock is slow.
 */
module fagb_backend_tb
    import fagb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {int lvl; logic [7:0] w; logic o;} fagb_row_s;
    fagb_row_s rows [13] = '{'{0, 8'h00, 1'b0}, '{1, 8'h01, 1'b0}, '{63, 8'h20, 1'b0},
        '{64, 8'h60, 1'b0}, '{65, 8'h61, 1'b0}, '{127, 8'h40, 1'b0}, '{128, 8'hc0, 1'b0},
        '{191, 8'he0, 1'b0}, '{192, 8'ha0, 1'b0}, '{254, 8'h81, 1'b0}, '{255, 8'h80, 1'b0},
        '{256, 8'h80, 1'b1}, '{128, 8'hc0, 1'b0}};

    logic         i_mclk;
    logic         i_resetn;
    logic         i_conv_clk;
    logic [255:0] i_comparator;
    logic [7:0]   sw_a, sw_b, exp_wa, exp_wb, pend_w, nloads, cap_n, cap_w;
    logic         ov_a, ov_b, rd_a, rd_b, rdn_a, rdn_b, cap_bank;
    logic         exp_oa, exp_ob, exp_ra, exp_rb, sel, pend_v, pend_o;
    int           n_fail;
    int           total_checks;

    fagb_backend dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_conv_clk(i_conv_clk),
        .i_comparator(i_comparator), .o_sample_word_bank_a(sw_a), .o_overrange_bank_a(ov_a),
        .o_ready_strobe_bank_a(rd_a), .o_ready_strobe_n_bank_a(rdn_a), .o_sample_word_bank_b(sw_b),
        .o_overrange_bank_b(ov_b), .o_ready_strobe_bank_b(rd_b), .o_ready_strobe_n_bank_b(rdn_b));

    fagb_capture_model far_end (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_word_a(sw_a),
        .i_rdy_a(rd_a), .i_word_b(sw_b), .i_rdy_b(rd_b), .o_count(cap_n), .o_word(cap_w),
        .o_bank(cap_bank));

    always #20 i_mclk = ~i_mclk;

    task automatic stop_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [7:0] a, input logic [7:0] e, input string m);
        total_checks++;
        if (a !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h expected %h", $time, m, a, e);
        end
    endtask

    task automatic cmp_bit(input logic a, input logic e, input string m);
        total_checks++;
        if (a !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s got %b expected %b", $time, m, a, e);
        end
    endtask

    task automatic check_all();
        cmp_word(sw_a, exp_wa, "word a");
        cmp_word(sw_b, exp_wb, "word b");
        cmp_bit(ov_a, exp_oa, "overrange a");
        cmp_bit(ov_b, exp_ob, "overrange b");
        cmp_bit(rd_a, exp_ra, "ready a");
        cmp_bit(rd_b, exp_rb, "ready b");
        cmp_bit(rdn_a, ~exp_ra, "ready_n a");
        cmp_bit(rdn_b, ~exp_rb, "ready_n b");
        cmp_word(cap_n, nloads, "load count");
        if (nloads != 8'h00) begin
            cmp_bit(cap_bank, ~sel, "last bank");
            cmp_word(cap_w, sel ? exp_wa : exp_wb, "captured word");
        end
    endtask

    // One converter period: low 4 cycles with a check, high 4 cycles
    task automatic conv_cycle(input logic [255:0] comp, input logic [7:0] w, input logic o);
        i_conv_clk = 1'b0;
        i_comparator = comp;
        repeat (2) @(negedge i_mclk);
        check_all();
        repeat (2) @(negedge i_mclk);
        i_conv_clk = 1'b1;
        if (pend_v) begin
            if (sel) begin
                exp_wb = pend_w;
                exp_ob = pend_o;
                exp_rb = ~exp_rb;
            end else begin
                exp_wa = pend_w;
                exp_oa = pend_o;
                exp_ra = ~exp_ra;
            end
            sel = ~sel;
            nloads = nloads + 8'h01;
        end
        pend_w = w;
        pend_o = o;
        pend_v = 1'b1;
        repeat (4) @(negedge i_mclk);
    endtask

    task automatic do_reset(input int n);
        i_resetn = 1'b0;
        i_conv_clk = 1'b0;
        {exp_wa, exp_wb, exp_oa, exp_ob, exp_ra, exp_rb} = '0;
        {sel, pend_v} = 2'h0;
        nloads = 8'h00;
        repeat (n) @(negedge i_mclk);
        i_resetn = 1'b1;
    endtask

    function automatic logic [255:0] lvl_vec(input int n);
        return (n >= 256) ? '1 : ((256'h1 << n) - 256'h1);
    endfunction

    initial begin
        #200us;
        n_fail++;
        stop_test();
    end

    initial begin
        {i_mclk, i_conv_clk, i_resetn, i_comparator} = '0;
        {n_fail, total_checks} = '0;
        @(negedge i_mclk);
        do_reset(20);
        check_all();
        foreach (rows[i]) begin
            conv_cycle(lvl_vec(rows[i].lvl), rows[i].w, rows[i].o);
        end
        // Bubbled codes: stray bits in columns above the partial column do not count
        conv_cycle(256'h3ff | (256'h1 << 70), 8'h0f, 1'b0);
        conv_cycle(((256'h1 << 68) - 256'h1) | (256'h1 << 200), 8'h66, 1'b0);
        conv_cycle(256'h0, 8'h00, 1'b0);
        do_reset(2);
        check_all();
        conv_cycle(lvl_vec(128), 8'hc0, 1'b0);
        conv_cycle(lvl_vec(64), 8'h60, 1'b0);
        conv_cycle(lvl_vec(256), 8'h80, 1'b1);
        conv_cycle(256'h0, 8'h00, 1'b0);
        conv_cycle(256'h0, 8'h00, 1'b0);
        i_conv_clk = 1'b0;
        repeat (2) @(negedge i_mclk);
        check_all();
        stop_test();
    end
endmodule
